/* verilog/nvm_command_status_regs.v */
// Command and status registers of the nonvolatile memory controller
`timescale 1ns/1ps
`include "nvm_regs_defs.vh"

// Behaviour
// - Busy rises when an operation starts and holds until it completes.
// - Busy covers operations on the flash array and on the lock bits.
// - Bits 6 to 0 of the status register always read as zero.
// - Command bits 7 and 6 read as zero; only bits 5 to 0 are writable.
// - A six-bit command field selects the action of the next trigger.
// - Command code zero makes a trigger do nothing.
// - Command 0x10 makes a trigger erase the code array and lock bits.
// - Command 0x14 makes a trigger erase the section of the addressed word.
// - Command 0x1D makes a trigger program the addressed word.
// - Command register writes are ignored while the busy flag is set.
// - Word programming buffers the low byte and starts on the high byte.
// - An erase starts on a write of any byte to the high byte of a word.
// - While programming, memory reads and other programming are blocked.

module nvm_command_status_regs (
    input  wire        mclk,
    input  wire        rst,
    // I/O space register port
    input  wire [5:0]  io_addr,
    input  wire [7:0]  io_wdata,
    input  wire        io_we,
    input  wire        io_re,
    output reg  [7:0]  io_rdata_reg,
    // Data-space port for the mapped memory
    input  wire [15:0] ds_addr,
    input  wire [7:0]  ds_wdata,
    input  wire        ds_we,
    input  wire        ds_re,
    output reg  [7:0]  ds_rdata_reg,
    output reg         ds_rvalid_reg,
    output reg         ds_blocked_reg,
    // Array side
    output wire        array_rd_en,
    output wire [14:0] array_rd_addr,
    input  wire [15:0] array_rdata,
    output reg         op_start_reg,
    output reg  [2:0]  op_kind_reg,
    output reg         op_lock_reg,
    output reg  [14:0] op_addr_reg,
    output reg  [15:0] op_data_reg,
    input  wire        op_done,
    // Status
    output wire        nvm_busy_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Controller states

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN  = 2'b10;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [5:0]  cmd_reg;
    reg  [5:0]  cmd_next;

    // Next values of the output registers
    reg  [7:0]  io_rdata_next;
    reg  [7:0]  ds_rdata_next;
    reg         ds_rvalid_next;
    reg         ds_blocked_next;
    reg  [2:0]  op_kind_next;
    reg         op_lock_next;
    reg  [14:0] op_addr_next;
    reg  [15:0] op_data_next;

    wire [2:0]  dec_kind;
    wire        dec_defined;
    wire [7:0]  buf_low;
    wire [14:0] buf_addr;
    wire        buf_full;

    wire        busy;
    wire [14:0] ds_word;
    wire        ds_high;
    wire        hit_lock;
    wire        low_write;
    wire        high_write;
    wire        is_program;
    wire        program_ok;
    wire        trigger;
    wire        start;
    wire [15:0] start_data;
    wire        cmd_write;
    wire        rd_served;
    wire [7:0]  status_word;
    wire [7:0]  command_word;

    ////////////////////////////////////////////////////////////////////////
    // Data-space address split

    // Bit 0 picks the byte, the rest picks the word
    assign ds_word  = ds_addr[15:1];
    assign ds_high  = ds_addr[0];
    assign hit_lock = (ds_word == `LOCK_WORD_ADDR);

    // Busy is the run state; it spans the whole array operation
    assign busy          = state_reg[1];
    assign nvm_busy_flag = busy;

    ////////////////////////////////////////////////////////////////////////
    // Command decode

    nvm_cmd_decode u_decode (
        .cmd     (cmd_reg),
        .kind    (dec_kind),
        .defined (dec_defined)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write sequencing on the data-space port

    // Writes while busy never reach the buffer or trigger anything
    assign low_write  = ds_we & ~busy & ~ds_high;
    assign high_write = ds_we & ~busy & ds_high;
    assign is_program = (dec_kind == `OP_KIND_PROGRAM_WORD);

    // Program needs the low byte of the same word buffered first
    assign program_ok = buf_full & (buf_addr == ds_word);

    // Erase starts on any high byte; program only after its low byte
    assign trigger = high_write & dec_defined &
                     (~is_program | program_ok);
    assign start   = trigger;

    assign start_data = {ds_wdata, buf_low};

    nvm_word_buffer u_buffer (
        .mclk         (mclk),
        .rst          (rst),
        .load         (low_write),
        .consume      (high_write),
        .word_addr    (ds_word),
        .low_byte     (ds_wdata),
        .low_byte_reg (buf_low),
        .addr_reg     (buf_addr),
        .full_reg     (buf_full)
    );

    ////////////////////////////////////////////////////////////////////////
    // Controller state machine

    // Leaves the run state only when the array reports completion
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (op_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation issue to the array

    // Kind, address and data stay put for the whole operation
    always @* begin
        op_kind_next = op_kind_reg;
        op_lock_next = op_lock_reg;
        op_addr_next = op_addr_reg;
        op_data_next = op_data_reg;
        if (start) begin
            op_kind_next = dec_kind;
            op_addr_next = ds_word;
            op_data_next = start_data;
            // Full erase always clears the lock bits too
            op_lock_next = hit_lock |
                (dec_kind == `OP_KIND_ERASE_ALL);
        end
    end

    // Start is a one-cycle pulse; the rest moves only on a start
    always @(posedge mclk) begin
        if (rst) begin
            op_start_reg <= 1'b0;
            op_kind_reg  <= `OP_KIND_NONE;
            op_lock_reg  <= 1'b0;
            op_addr_reg  <= 15'h0000;
            op_data_reg  <= 16'h0000;
        end else begin
            op_start_reg <= start;
            op_kind_reg  <= op_kind_next;
            op_lock_reg  <= op_lock_next;
            op_addr_reg  <= op_addr_next;
            op_data_reg  <= op_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command register

    // Command writes land only while idle, so a running command is kept
    assign cmd_write = io_we & (io_addr == `NVM_COMMAND_OFFSET) & ~busy;

    // Upper two bits are not stored at all; writes ignored while busy
    always @* begin
        cmd_next = cmd_reg;
        if (cmd_write) begin
            cmd_next = io_wdata[`NVM_CMD_MSB:`NVM_CMD_LSB];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            cmd_reg <= `NVM_COMMAND_RESET;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register images as read back

    // Reserved bits are constant zero and never stored
    assign status_word  = {busy, 7'h00};
    assign command_word = {2'b00, cmd_reg};

    ////////////////////////////////////////////////////////////////////////
    // I/O register read-back

    // Unmapped offsets and idle cycles read as zero
    always @* begin
        io_rdata_next = 8'h00;
        if (io_re) begin
            case (io_addr)
                `NVM_STATUS_OFFSET: begin
                    io_rdata_next = status_word;
                end
                `NVM_COMMAND_OFFSET: begin
                    io_rdata_next = command_word;
                end
                default: begin
                    io_rdata_next = 8'h00;
                end
            endcase
        end
    end

    // Answer stands for one cycle only, then falls back to zero
    always @(posedge mclk) begin
        if (rst) begin
            io_rdata_reg <= 8'h00;
        end else begin
            io_rdata_reg <= io_rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory reads on the data-space port

    // Array read only when idle, so a running operation is never disturbed
    assign rd_served     = ds_re & ~busy;
    assign array_rd_en   = rd_served;
    assign array_rd_addr = ds_word;

    // Blocked reads give zero and a flag instead of array data
    always @* begin
        ds_rdata_next   = 8'h00;
        ds_rvalid_next  = ds_re;
        ds_blocked_next = ds_re & busy;
        if (rd_served) begin
            ds_rdata_next = ds_high ? array_rdata[15:8]
                                    : array_rdata[7:0];
        end
    end

    // Answer one cycle after the read, served or blocked
    always @(posedge mclk) begin
        if (rst) begin
            ds_rdata_reg   <= 8'h00;
            ds_rvalid_reg  <= 1'b0;
            ds_blocked_reg <= 1'b0;
        end else begin
            ds_rdata_reg   <= ds_rdata_next;
            ds_rvalid_reg  <= ds_rvalid_next;
            ds_blocked_reg <= ds_blocked_next;
        end
    end

endmodule // nvm_command_status_regs

/* verilog/nvm_regs_defs.vh */
// Constants for the nonvolatile memory command and status block
`ifndef NVM_REGS_DEFS_VH
`define NVM_REGS_DEFS_VH

// I/O space offsets of the two registers
`define NVM_STATUS_OFFSET     6'h32
`define NVM_COMMAND_OFFSET    6'h33

// Reset values
`define NVM_STATUS_RESET      8'h00
`define NVM_COMMAND_RESET     6'h00

// Field positions
`define NVM_BUSY_BIT          7
`define NVM_CMD_MSB           5
`define NVM_CMD_LSB           0
`define NVM_CMD_WIDTH         6

// Command codes held in nvm_command_field
`define NO_OP_CODE               6'h00
`define FULL_ARRAY_ERASE_CODE    6'h10
`define REGION_ERASE_CODE        6'h14
`define SINGLE_WORD_PROGRAM_CODE 6'h1d

// Operation kinds issued to the array, one-hot
`define OP_KIND_WIDTH         3
`define OP_KIND_NONE          3'h0
`define OP_KIND_ERASE_ALL     3'h1
`define OP_KIND_ERASE_REGION  3'h2
`define OP_KIND_PROGRAM_WORD  3'h4

// Data-space word address of the lock word
`define LOCK_WORD_ADDR        15'h1f00

`endif

/* verilog/nvm_cmd_decode.v */
// Decoder from command field to one-hot operation kind
`timescale 1ns/1ps
`include "nvm_regs_defs.vh"

module nvm_cmd_decode (
    input  wire [5:0] cmd,
    output reg  [2:0] kind,
    output reg        defined
);

    // Unknown codes map to no operation so a trigger does nothing
    always @* begin
        kind    = `OP_KIND_NONE;
        defined = 1'b0;
        case (cmd)
            `FULL_ARRAY_ERASE_CODE: begin
                kind    = `OP_KIND_ERASE_ALL;
                defined = 1'b1;
            end
            `REGION_ERASE_CODE: begin
                kind    = `OP_KIND_ERASE_REGION;
                defined = 1'b1;
            end
            `SINGLE_WORD_PROGRAM_CODE: begin
                kind    = `OP_KIND_PROGRAM_WORD;
                defined = 1'b1;
            end
            default: begin
                kind    = `OP_KIND_NONE;
                defined = 1'b0;
            end
        endcase
    end

endmodule // nvm_cmd_decode

/* verilog/nvm_word_buffer.v */
// Temporary holder for the low byte of a word being programmed
`timescale 1ns/1ps
`include "nvm_regs_defs.vh"

module nvm_word_buffer (
    input  wire        mclk,
    input  wire        rst,
    input  wire        load,
    input  wire        consume,
    input  wire [14:0] word_addr,
    input  wire [7:0]  low_byte,
    output reg  [7:0]  low_byte_reg,
    output reg  [14:0] addr_reg,
    output reg         full_reg
);

    // Low byte waits here until the next high-byte write, to any word, arrives
    always @(posedge mclk) begin
        if (rst) begin
            low_byte_reg <= 8'h00;
            addr_reg     <= 15'h0000;
            full_reg     <= 1'b0;
        end else if (load) begin
            low_byte_reg <= low_byte;
            addr_reg     <= word_addr;
            full_reg     <= 1'b1;
        end else if (consume) begin
            full_reg     <= 1'b0;
        end
    end

endmodule // nvm_word_buffer

/* sim/nvm_array_model.sv */
// Array model that finishes each operation after a set delay
`timescale 1ns/1ps
module nvm_array_model (
    input  wire        mclk,
    input  wire        rst,
    input  wire        op_start,
    input  wire [7:0]  delay,
    input  wire [14:0] rd_addr,
    output wire [15:0] rdata,
    output reg         op_done
);
    reg [7:0] cnt_reg;
    // Word pattern tied to its address, so stale data shows
    assign rdata = {~rd_addr[7:0], rd_addr[7:0]};
    // Done pulse a set delay after each start
    always @(posedge mclk) begin
        op_done <= 1'b0;
        if (rst)
            cnt_reg <= 8'h00;
        else if (op_start)
            cnt_reg <= delay;
        else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
            op_done <= (cnt_reg == 8'h01);
        end
    end
endmodule // nvm_array_model

/* sim/nvm_regs_props.sv */
// Checker of the command and status block
`timescale 1ns/1ps
module nvm_regs_props (
    input wire        mclk,
    input wire        rst,
    input wire [5:0]  io_addr,
    input wire        io_re,
    input wire [7:0]  io_rdata_reg,
    input wire [15:0] ds_addr,
    input wire        ds_we,
    input wire        ds_re,
    input wire [7:0]  ds_rdata_reg,
    input wire        ds_blocked_reg,
    input wire        array_rd_en,
    input wire        op_start_reg,
    input wire [2:0]  op_kind_reg,
    input wire        op_lock_reg,
    input wire        op_done,
    input wire        nvm_busy_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    reg trig_q;
    // Trigger seen while idle, one cycle late
    always @(posedge mclk)
        trig_q <= !rst && ds_we && ds_addr[0] && !nvm_busy_flag;
    sequence start_s;
        op_start_reg && nvm_busy_flag ##1 !op_start_reg;
    endsequence
    chk_start_busy: assert property (op_start_reg |-> start_s)
        else $error("start without busy or too long");
    chk_busy_holds: assert property (nvm_busy_flag && !op_done
        |=> nvm_busy_flag) else $error("busy dropped early");
    chk_busy_ends: assert property (nvm_busy_flag && op_done
        && !op_start_reg |=> !nvm_busy_flag) else $error("busy stuck");
    chk_stat_resv: assert property (io_re && io_addr == 6'h32
        |=> io_rdata_reg[6:0] == 7'h00) else $error("status low bits");
    chk_cmd_upper: assert property (io_re && io_addr == 6'h33
        |=> io_rdata_reg[7:6] == 2'b00) else $error("command top bits");
    chk_start_cause: assert property (op_start_reg |-> trig_q)
        else $error("start without trigger");
    chk_read_block: assert property (ds_re && nvm_busy_flag
        |=> ds_blocked_reg && ds_rdata_reg == 8'h00)
        else $error("read not blocked");
    chk_no_array: assert property (nvm_busy_flag
        |-> !array_rd_en) else $error("array read while busy");
    chk_no_restart: assert property (nvm_busy_flag
        |=> !op_start_reg) else $error("start while busy");
    chk_erase_lock: assert property (op_start_reg
        && op_kind_reg == 3'h1 |-> op_lock_reg)
        else $error("erase all without lock");
    chk_kind_hot: assert property (op_start_reg
        |-> $onehot(op_kind_reg)) else $error("bad kind");
endmodule // nvm_regs_props

bind nvm_command_status_regs nvm_regs_props nvm_regs_props_i (
    .mclk(mclk), .rst(rst), .io_addr(io_addr), .io_re(io_re),
    .io_rdata_reg(io_rdata_reg), .ds_addr(ds_addr), .ds_we(ds_we),
    .ds_re(ds_re), .ds_rdata_reg(ds_rdata_reg),
    .ds_blocked_reg(ds_blocked_reg), .array_rd_en(array_rd_en),
    .op_start_reg(op_start_reg), .op_kind_reg(op_kind_reg),
    .op_lock_reg(op_lock_reg), .op_done(op_done),
    .nvm_busy_flag(nvm_busy_flag)
);

/* sim/nvm_command_status_regs_tb.sv */
// Testbench of the command and status block
`timescale 1ns/1ps
module nvm_command_status_regs_tb;
    reg         mclk = 1'b0;
    reg         rst = 1'b1;
    reg  [5:0]  io_addr = 6'h00;
    reg  [7:0]  io_wdata = 8'h00;
    reg         io_we = 1'b0;
    reg         io_re = 1'b0;
    reg  [15:0] ds_addr = 16'h0000;
    reg  [7:0]  ds_wdata = 8'h00;
    reg         ds_we = 1'b0;
    reg         ds_re = 1'b0;
    reg  [7:0]  delay = 8'h03;
    wire [7:0]  io_rdata_reg, ds_rdata_reg;
    wire        ds_blocked_reg, array_rd_en, op_start_reg, op_lock_reg;
    wire        op_done, nvm_busy_flag, ds_rvalid_reg;
    wire [14:0] array_rd_addr, op_addr_reg;
    wire [15:0] array_rdata, op_data_reg;
    wire [2:0]  op_kind_reg;
    integer     fail_count = 0;
    integer     check_count = 0;
    integer     i;
    nvm_command_status_regs nvm_command_status_regs_i (
        .mclk(mclk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_we(io_we), .io_re(io_re), .io_rdata_reg(io_rdata_reg),
        .ds_addr(ds_addr), .ds_wdata(ds_wdata), .ds_we(ds_we),
        .ds_re(ds_re), .ds_rdata_reg(ds_rdata_reg),
        .ds_rvalid_reg(ds_rvalid_reg),
        .ds_blocked_reg(ds_blocked_reg), .array_rd_en(array_rd_en),
        .array_rd_addr(array_rd_addr), .array_rdata(array_rdata),
        .op_start_reg(op_start_reg), .op_kind_reg(op_kind_reg),
        .op_lock_reg(op_lock_reg), .op_addr_reg(op_addr_reg),
        .op_data_reg(op_data_reg), .op_done(op_done),
        .nvm_busy_flag(nvm_busy_flag));
    nvm_array_model nvm_array_model_i (
        .mclk(mclk), .rst(rst), .op_start(op_start_reg), .delay(delay),
        .rd_addr(array_rd_addr), .rdata(array_rdata), .op_done(op_done));
    initial forever #50 mclk = ~mclk;
    // Compare and count
    task chk(input [39:0] n, input [15:0] seen, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0s exp %h seen %h", n, exp, seen);
            end
        end
    endtask
    // One register access; result settled at the falling edge
    task io_op(input [5:0] a, input [7:0] d, input we);
        begin
            @(posedge mclk);
            io_addr <= a;
            io_wdata <= d;
            io_we <= we;
            io_re <= ~we;
            @(posedge mclk);
            io_we <= 1'b0;
            io_re <= 1'b0;
            @(negedge mclk);
        end
    endtask
    // One data-space access
    task ds_op(input [15:0] a, input [7:0] d, input we);
        begin
            @(posedge mclk);
            ds_addr <= a;
            ds_wdata <= d;
            ds_we <= we;
            ds_re <= ~we;
            @(posedge mclk);
            ds_we <= 1'b0;
            ds_re <= 1'b0;
            @(negedge mclk);
        end
    endtask
    // Bounded wait for the operation to finish
    task wait_idle;
        begin
            for (i = 0; i < 100 && nvm_busy_flag !== 1'b0; i = i + 1)
                @(negedge mclk);
            if (nvm_busy_flag !== 1'b0) begin
                fail_count = fail_count + 1;
                end_of_test;
            end
        end
    endtask
    // Status reset value and writable bits
    task t_regs;
        begin
            io_op(6'h32, 8'h00, 1'b0);
            chk("stat", io_rdata_reg, 8'h00);
            io_op(6'h33, 8'hff, 1'b1);
            io_op(6'h33, 8'h00, 1'b0);
            chk("cmd", io_rdata_reg, 8'h3f);
            io_op(6'h32, 8'hff, 1'b1);
            io_op(6'h32, 8'h00, 1'b0);
            chk("stat", io_rdata_reg, 8'h00);
        end
    endtask
    // Command, low byte, then high byte as the trigger
    task t_op(input [5:0] c, input [15:0] a, input [2:0] k, input l,
              input w);
        begin
            io_op(6'h33, {2'b00, c}, 1'b1);
            ds_op(a, 8'h34, 1'b1);
            ds_op(a | 16'h0001, 8'h12, 1'b1);
            chk("start", op_start_reg, k != 3'h0);
            chk("busy", nvm_busy_flag, k != 3'h0);
            if (k != 3'h0) begin
                chk("kind", op_kind_reg, k);
                chk("lock", op_lock_reg, l);
            end
            if (k == 3'h4) begin
                chk("addr", op_addr_reg, a[15:1]);
                chk("data", op_data_reg, 16'h1234);
            end
            // The busy scenario returns with the operation still running
            if (w)
                wait_idle;
        end
    endtask
    // Slow operation: writes and reads while busy
    task t_busy;
        begin
            delay <= 8'h28;
            t_op(6'h14, 16'h0020, 3'h2, 1'b0, 1'b0);
            io_op(6'h33, 8'h1d, 1'b1);
            io_op(6'h33, 8'h00, 1'b0);
            chk("cmd", io_rdata_reg, 8'h14);
            io_op(6'h32, 8'h00, 1'b0);
            chk("stat", io_rdata_reg, 8'h80);
            ds_op(16'h0011, 8'h00, 1'b0);
            chk("blk", ds_blocked_reg, 1'b1);
            chk("rvld", ds_rvalid_reg, 1'b1);
            ds_op(16'h0031, 8'h00, 1'b1);
            chk("start", op_start_reg, 1'b0);
            wait_idle;
            ds_op(16'h0011, 8'h00, 1'b0);
            chk("rd", ds_rdata_reg, 8'hf7);
            chk("rvld", ds_rvalid_reg, 1'b1);
            chk("blk", ds_blocked_reg, 1'b0);
            io_op(6'h32, 8'h00, 1'b0);
            chk("stat", io_rdata_reg, 8'h00);
        end
    endtask
    // Verdict
    task end_of_test;
        begin
            $display("checks %0d errors %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_op(6'h00, 16'h0010, 3'h0, 1'b0, 1'b1);
        t_op(6'h3f, 16'h0010, 3'h0, 1'b0, 1'b1);
        t_op(6'h10, 16'h0010, 3'h1, 1'b1, 1'b1);
        t_op(6'h1d, 16'h0010, 3'h4, 1'b0, 1'b1);
        t_op(6'h1d, 16'h3e00, 3'h4, 1'b1, 1'b1);
        t_busy;
        end_of_test;
    end
endmodule // nvm_command_status_regs_tb
